/* sbc_watchdog_config_unit.v */
// watchdog unit with non-volatile configuration register of a system basis chip
// assumes an spi front end that presents decoded byte accesses on one clock,
// and mode logic and non-volatile store on the same clock
`timescale 1ns/10ps
`include "sbc_wd_regs.vh"
module sbc_watchdog_config_unit #(
	parameter MS_TICK_CYCLES = `WD_MS_TICK_CYCLES,
	parameter TICK_W         = 18
) (
	input  wire         core_clk_i,
	input  wire         arst_n_i,
	input  wire         reg_wr_i,
	input  wire         reg_rd_i,
	input  wire [6:0]   reg_addr_i,
	input  wire [7:0]   reg_wdata_i,
	output reg  [7:0]   reg_rdata_o,
	input  wire         spi_fail_en_i,
	output reg          spi_fail_o,
	input  wire [2:0]   chip_mode_i,
	input  wire         rxd_low_i,
	input  wire         wake_event_i,
	input  wire         sys_reset_i,
	input  wire         wd_fail_clear_i,
	input  wire         nv_valid_i,
	input  wire [7:0]   nv_data_i,
	output reg          nv_write_o,
	output reg  [7:0]   nv_wdata_o,
	input  wire         sleep_cmd_i,
	output wire         sleep_cmd_ok_o,
	output reg          sys_reset_o,
	output reg  [4:0]   reset_source_o,
	output reg          wd_fail_event_o,
	output reg          wd_wake_o,
	output reg          rxd_force_low_o,
	output reg          main_supply_on_o,
	output reg          goto_standby_o,
	output reg  [1:0]   uv_threshold_sel_o,
	output wire [1:0]   startup_uv_threshold_sel_o,
	output wire         forced_normal_flag_o,
	output wire         sw_dev_flag_o,
	output reg  [1:0]   wd_phase_o
);
	localparam ACT_OFF = 2'h0;
	localparam ACT_TO  = 2'h1;
	localparam ACT_WIN = 2'h2;

	reg         rst_meta;
	reg         rst_sync;
	wire        rst_n;
	reg  [7:0]  ctrl;
	reg  [7:0]  cfg;
	reg  [12:0] ms_cnt;
	reg  [1:0]  act;
	reg  [1:0]  act_q;
	reg  [1:0]  next_phase;
	wire        tick;
	wire        new_mode_ok;
	wire        new_period_ok;
	wire [12:0] new_period_ms;
	wire        cur_mode_ok;
	wire        cur_period_ok;
	wire [12:0] period_ms;
	wire [2:0]  wd_mode_field;
	wire [3:0]  wd_period_field;
	wire        forced_normal_enable;
	wire        sw_dev_enable;
	wire        forced_normal_state;
	wire        sw_dev_state;
	wire        chip_normal;
	wire        chip_standby;
	wire        chip_sleep;
	wire        rxd_low;
	wire        wr_ctrl;
	wire        wr_cfg;
	wire        codes_ok;
	wire        mode_change_normal;
	wire        in_first_half;
	wire        early_trigger;
	wire        good_trigger;
	wire        expire;
	wire        expire_reset;
	wire        expire_fail;
	wire        sleep_timeout_wake;
	wire        auto_wake;
	wire        reset_event;
	wire        reload_defaults;
	wire        restart;
	wire [7:0]  ctrl_default;
	wire [7:0]  nv_ctrl_default;
	wire [2:0]  act_mode;

	// ==========================================================
	// reset release through two flops
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	assign rst_n = rst_sync;

	// ==========================================================
	// field views and overrides
	assign wd_mode_field        = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
	assign wd_period_field      = ctrl[`CTRL_PERIOD_HI:`CTRL_PERIOD_LO];
	assign forced_normal_enable = cfg[`CFG_FORCED_NORMAL];
	assign sw_dev_enable        = cfg[`CFG_SW_DEV];
	assign forced_normal_state  = forced_normal_enable;
	assign sw_dev_state         = sw_dev_enable & ~forced_normal_enable;
	assign forced_normal_flag_o = forced_normal_state;
	assign sw_dev_flag_o        = sw_dev_state;
	assign startup_uv_threshold_sel_o = cfg[`CFG_UV_HI:`CFG_UV_LO];
	assign sleep_cmd_ok_o       = sleep_cmd_i & ~cfg[`CFG_SLEEP_LOCK];

	assign chip_normal  = (chip_mode_i == `CHIP_NORMAL);
	assign chip_standby = (chip_mode_i == `CHIP_STANDBY);
	assign chip_sleep   = (chip_mode_i == `CHIP_SLEEP);
	assign rxd_low      = rxd_low_i | rxd_force_low_o;

	// default control value; autonomous when sw-dev is on after reset
	assign ctrl_default    = {(sw_dev_state ? `MODE_AUTONOMOUS : `MODE_TIMEOUT),
		1'b0, `PERIOD_DEFAULT};
	assign nv_ctrl_default = {((nv_data_i[`CFG_SW_DEV] & ~nv_data_i[`CFG_FORCED_NORMAL]) ?
		`MODE_AUTONOMOUS : `MODE_TIMEOUT), 1'b0, `PERIOD_DEFAULT};

	// ==========================================================
	// code checks for the incoming byte and for the held byte
	wd_code_check u_new_check (
		.ctrl_i      (reg_wdata_i),
		.mode_ok_o   (new_mode_ok),
		.period_ok_o (new_period_ok),
		.period_ms_o (new_period_ms)
	);

	wd_code_check u_cur_check (
		.ctrl_i      (ctrl),
		.mode_ok_o   (cur_mode_ok),
		.period_ok_o (cur_period_ok),
		.period_ms_o (period_ms)
	);

	// ==========================================================
	// effective watchdog behaviour per chip mode
	// a good write rules in its own cycle, so phase shows 01 at once if the written mode is active in this chip mode
	assign act_mode = (wr_ctrl & codes_ok & ~mode_change_normal) ?
		reg_wdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO] : wd_mode_field;

	always @* begin
		act = ACT_OFF;
		if (!forced_normal_state) begin
			case (act_mode)
				`MODE_WINDOW: begin
					if (chip_normal)
						act = ACT_WIN;
					else if (chip_standby | chip_sleep)
						act = ACT_TO;
				end
				`MODE_TIMEOUT: begin
					if (chip_normal | chip_standby | chip_sleep)
						act = ACT_TO;
				end
				`MODE_AUTONOMOUS: begin
					if (!sw_dev_state) begin
						if (chip_normal)
							act = ACT_TO;
						else if (chip_standby & rxd_low)
							act = ACT_TO;
					end
				end
				default: act = ACT_OFF;
			endcase
		end
	end

	// ==========================================================
	// accesses and trigger classification
	assign wr_ctrl  = reg_wr_i & (reg_addr_i == `ADDR_WD_CONTROL);
	assign wr_cfg   = reg_wr_i & (reg_addr_i == `ADDR_NV_CONFIG);
	assign codes_ok = new_mode_ok & new_period_ok;

	assign mode_change_normal = wr_ctrl & codes_ok & chip_normal &
		(reg_wdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO] != wd_mode_field);
	assign in_first_half = (ms_cnt < {1'b0, period_ms[12:1]});
	assign early_trigger = wr_ctrl & codes_ok & ~mode_change_normal &
		(act == ACT_WIN) & in_first_half;
	assign good_trigger  = wr_ctrl & codes_ok & ~mode_change_normal &
		~early_trigger;

	assign expire = tick & (act != ACT_OFF) &
		(ms_cnt == period_ms - 13'h0001);
	assign expire_reset = expire & ~good_trigger &
		((act == ACT_WIN) | wd_fail_event_o);
	assign expire_fail  = expire & ~good_trigger & (act == ACT_TO) &
		~wd_fail_event_o;
	assign sleep_timeout_wake = expire_fail & chip_sleep;
	assign auto_wake = wake_event_i & ~forced_normal_state &
		(wd_mode_field == `MODE_AUTONOMOUS) & ~sw_dev_state &
		(chip_standby | chip_sleep);

	assign reset_event     = mode_change_normal | early_trigger | expire_reset;
	assign reload_defaults = sys_reset_o | sys_reset_i;
	// a fresh activation must start the period from zero, not mid-count
	assign restart = good_trigger | expire | reload_defaults |
		((act != ACT_OFF) & (act_q == ACT_OFF));

	// ==========================================================
	// millisecond tick and period counter
	wd_ms_tick #(
		.CYCLES (MS_TICK_CYCLES),
		.W      (TICK_W)
	) u_tick (
		.clk_i     (core_clk_i),
		.rst_n_i   (rst_n),
		.restart_i (good_trigger | reload_defaults),
		.tick_o    (tick)
	);

	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt <= 13'h0000;
			act_q  <= ACT_OFF;
		end else begin
			act_q <= act;
			if (restart | (act == ACT_OFF))
				ms_cnt <= 13'h0000;
			else if (tick)
				ms_cnt <= ms_cnt + 13'h0001;
		end
	end

	always @* begin
		if (act == ACT_OFF)
			next_phase = `PHASE_OFF;
		else if (good_trigger | in_first_half)
			next_phase = `PHASE_FIRST;
		else
			next_phase = `PHASE_SECOND;
	end

	// ==========================================================
	// control register
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= {`MODE_TIMEOUT, 1'b0, `PERIOD_DEFAULT};
		end else if (nv_valid_i) begin
			ctrl <= nv_ctrl_default;
		end else if (reload_defaults) begin
			ctrl <= ctrl_default;
		end else if (good_trigger) begin
			// invalid codes never reach here, so the access is dropped whole
			ctrl <= {reg_wdata_i[7:5], 1'b0, reg_wdata_i[3:0]};
		end
	end

	// ==========================================================
	// configuration register mirrored to the non-volatile store
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg                <= `CFG_FACTORY;
			uv_threshold_sel_o <= 2'h0;
			nv_write_o         <= 1'b0;
			nv_wdata_o         <= 8'h00;
		end else begin
			nv_write_o <= wr_cfg;
			if (nv_valid_i) begin
				cfg                <= nv_data_i & 8'h3d;
				uv_threshold_sel_o <= nv_data_i[`CFG_UV_HI:`CFG_UV_LO];
			end else if (wr_cfg) begin
				cfg        <= reg_wdata_i & 8'h3d;
				nv_wdata_o <= reg_wdata_i & 8'h3d;
			end
		end
	end

	// ==========================================================
	// events, reset request and wake-up outputs
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			spi_fail_o       <= 1'b0;
			sys_reset_o      <= 1'b0;
			reset_source_o   <= 5'h00;
			wd_fail_event_o  <= 1'b0;
			wd_wake_o        <= 1'b0;
			rxd_force_low_o  <= 1'b0;
			main_supply_on_o <= 1'b0;
			goto_standby_o   <= 1'b0;
			wd_phase_o       <= `PHASE_OFF;
		end else begin
			spi_fail_o     <= wr_ctrl & ~codes_ok & spi_fail_en_i;
			sys_reset_o    <= reset_event;
			goto_standby_o <= auto_wake & chip_sleep;
			wd_wake_o      <= sleep_timeout_wake | auto_wake;
			wd_phase_o     <= next_phase;
			if (mode_change_normal)
				reset_source_o <= `RSRC_ILLEGAL_MODE;
			else if (early_trigger)
				reset_source_o <= `RSRC_EARLY;
			else if (expire_reset)
				reset_source_o <= `RSRC_OVERFLOW;
			// a new failure in the clearing cycle is kept
			wd_fail_event_o <= expire_fail | (wd_fail_event_o & ~wd_fail_clear_i);
			if (sleep_timeout_wake | auto_wake)
				rxd_force_low_o <= 1'b1;
			else if (good_trigger | reload_defaults)
				rxd_force_low_o <= 1'b0;
			if (sleep_timeout_wake)
				main_supply_on_o <= 1'b1;
			else if (!chip_sleep)
				main_supply_on_o <= 1'b0;
		end
	end

	// ==========================================================
	// register read port, data valid one cycle after the strobe
	always @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`ADDR_WD_CONTROL: reg_rdata_o <= ctrl;
				`ADDR_WD_STATUS:  reg_rdata_o <= {4'h0, forced_normal_state,
					sw_dev_state, wd_phase_o};
				`ADDR_NV_CONFIG:  reg_rdata_o <= cfg;
				default:          reg_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule

/* sbc_wd_regs.vh */
// constants of the watchdog and configuration unit: offsets, fields, codes, timing
// assumes inclusion by bare name from the design files of the unit that use it
//
// Contract
// - mode field bits 7:5, autonomous/timeout/window codes
// - window code in standby/sleep runs as timeout
// - period field bits 3:0 decodes eight periods
// - valid codes differ in two bits minimum
// - invalid code write discarded, spi failure captured
// - forced-normal enable keeps watchdog disabled; a mode change written in normal still resets, source 10000
// - forced-normal overrules software-development enable
// - configuration register kept in non-volatile store
// - config bits 5:4 give start-up undervoltage threshold
// - sleep-lock bit set ignores sleep commands
// - status bits 3,2 show forced-normal, sw-dev
// - status bits 1:0 show watchdog half-period phase
// - sw-dev enabled loads autonomous code after reset
// - autonomous with sw-dev keeps watchdog off
// - window: expiry or early trigger resets system
// - window: second-half trigger restarts timer
// - timeout: any trigger restarts timer
// - timeout expiry sets fail flag, again resets
// - sleep timeout expiry wakes, rxd low, supply on
// - autonomous stops in standby/sleep, wake restarts timeout
// - autonomous wake in sleep moves chip to standby
// - valid control write is a trigger unless early or a mode change in normal
// - mode write in normal resets, source 10000
// - sources 01110 early trigger, 01111 overflow
// - valid control write restarts period, sets phase 01 if watchdog active
`ifndef SBC_WD_REGS_VH
`define SBC_WD_REGS_VH

// ==========================================================
// register offsets
`define ADDR_WD_CONTROL     7'h00
`define ADDR_WD_STATUS      7'h05
`define ADDR_NV_CONFIG      7'h74

// ==========================================================
// control register fields
`define CTRL_MODE_HI        7
`define CTRL_MODE_LO        5
`define CTRL_PERIOD_HI      3
`define CTRL_PERIOD_LO      0
`define MODE_AUTONOMOUS     3'h1
`define MODE_TIMEOUT        3'h2
`define MODE_WINDOW         3'h4
`define PERIOD_8MS          4'h8
`define PERIOD_16MS         4'h1
`define PERIOD_32MS         4'h2
`define PERIOD_64MS         4'hb
`define PERIOD_128MS        4'h4
`define PERIOD_256MS        4'hd
`define PERIOD_1024MS       4'he
`define PERIOD_4096MS       4'h7
`define PERIOD_DEFAULT      4'h4

// ==========================================================
// configuration register fields
`define CFG_UV_HI           5
`define CFG_UV_LO           4
`define CFG_FORCED_NORMAL   3
`define CFG_SW_DEV          2
`define CFG_SLEEP_LOCK      0
`define CFG_FACTORY         8'h08

// ==========================================================
// status register fields
`define STAT_FORCED_NORMAL  3
`define STAT_SW_DEV         2
`define PHASE_OFF           2'h0
`define PHASE_FIRST         2'h1
`define PHASE_SECOND        2'h2

// ==========================================================
// chip modes and reset sources
`define CHIP_SLEEP          3'h1
`define CHIP_STANDBY        3'h4
`define CHIP_NORMAL         3'h7
`define RSRC_EARLY          5'h0e
`define RSRC_OVERFLOW       5'h0f
`define RSRC_ILLEGAL_MODE   5'h10

// ==========================================================
// timing
`define CLK_PERIOD_PS       5000
`define MS_TICK_TIME_NS     1000000
`define WD_MS_TICK_CYCLES   ((`MS_TICK_TIME_NS * 1000) / `CLK_PERIOD_PS)

`endif

/* wd_ms_tick.v */
// millisecond tick divider for the watchdog period counter
// assumes one clock and a synchronous restart from the owner
`timescale 1ns/10ps
module wd_ms_tick #(
	parameter CYCLES = 200000,
	parameter W      = 18
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire         restart_i,
	output reg          tick_o
);
	reg [W-1:0] div;

	// ==========================================================
	// divider; restart realigns so a new period starts on a whole ms
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div    <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (restart_i) begin
			div    <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (div == CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
			div    <= {W{1'b0}};
			tick_o <= 1'b1;
		end else begin
			div    <= div + {{(W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end
endmodule

/* wd_code_check.v */
// checks mode and period codes of a control byte and decodes the period in ms
// assumes a purely combinational use by the owner
`timescale 1ns/10ps
`include "sbc_wd_regs.vh"
module wd_code_check (
	input  wire [7:0]   ctrl_i,
	output reg          mode_ok_o,
	output reg          period_ok_o,
	output reg  [12:0]  period_ms_o
);
	wire [2:0] mode;
	wire [3:0] period;

	assign mode   = ctrl_i[`CTRL_MODE_HI:`CTRL_MODE_LO];
	assign period = ctrl_i[`CTRL_PERIOD_HI:`CTRL_PERIOD_LO];

	// ==========================================================
	// redundant codes: any single flipped bit lands on an invalid code
	always @* begin
		case (mode)
			`MODE_AUTONOMOUS: mode_ok_o = 1'b1;
			`MODE_TIMEOUT:    mode_ok_o = 1'b1;
			`MODE_WINDOW:     mode_ok_o = 1'b1;
			default:          mode_ok_o = 1'b0;
		endcase
	end

	always @* begin
		period_ok_o = 1'b1;
		case (period)
			`PERIOD_8MS:    period_ms_o = 13'h0008;
			`PERIOD_16MS:   period_ms_o = 13'h0010;
			`PERIOD_32MS:   period_ms_o = 13'h0020;
			`PERIOD_64MS:   period_ms_o = 13'h0040;
			`PERIOD_128MS:  period_ms_o = 13'h0080;
			`PERIOD_256MS:  period_ms_o = 13'h0100;
			`PERIOD_1024MS: period_ms_o = 13'h0400;
			`PERIOD_4096MS: period_ms_o = 13'h1000;
			default: begin
				period_ok_o = 1'b0;
				period_ms_o = 13'h0080;
			end
		endcase
	end
endmodule

/* sbc_wd_monitor.sv */
// checker on the ports of the watchdog and configuration unit
// assumes the shared header macros and one clock domain
`timescale 1ns/10ps
`include "sbc_wd_regs.vh"
module sbc_wd_monitor #(
	parameter MS_TICK_CYCLES = 10,
	parameter TICK_W         = 18
) (
	input wire       core_clk_i,
	input wire       arst_n_i,
	input wire       reg_wr_i,
	input wire [6:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire       spi_fail_en_i,
	input wire       spi_fail_o,
	input wire [2:0] chip_mode_i,
	input wire       wake_event_i,
	input wire       nv_valid_i,
	input wire [7:0] nv_data_i,
	input wire       nv_write_o,
	input wire [7:0] nv_wdata_o,
	input wire       sys_reset_o,
	input wire [4:0] reset_source_o,
	input wire       wd_wake_o,
	input wire       rxd_force_low_o,
	input wire       main_supply_on_o,
	input wire       goto_standby_o,
	input wire [1:0] uv_threshold_sel_o,
	input wire       forced_normal_flag_o,
	input wire       sw_dev_flag_o,
	input wire [1:0] wd_phase_o
);
	// ====
	// own code check, independent of the unit's decoder
	wire       mode_ok = reg_wdata_i[7:5] inside {3'h1, 3'h2, 3'h4};
	wire       per_ok  = reg_wdata_i[3:0] inside {4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
	reg  [7:0] wd_hold;
	reg  [1:0] uv_hold;
	always @(posedge core_clk_i) begin
		wd_hold <= reg_wdata_i;
		uv_hold <= nv_data_i[5:4];
	end
	// ====
	// properties
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_ctrl_wr; reg_wr_i && reg_addr_i == `ADDR_WD_CONTROL; endsequence
	sequence s_cfg_wr; reg_wr_i && reg_addr_i == `ADDR_NV_CONFIG; endsequence
	sequence s_rxd_low; ##[0:1] rxd_force_low_o; endsequence
	property p_bad_code; s_ctrl_wr ##0 (spi_fail_en_i && !(mode_ok && per_ok)) |=> spi_fail_o;
	endproperty
	property p_fail_cause; spi_fail_o |-> $past(reg_wr_i); endproperty
	property p_trig_phase; s_ctrl_wr ##0 (reg_wdata_i[7:5] == `MODE_TIMEOUT && per_ok &&
		chip_mode_i == `CHIP_STANDBY && !forced_normal_flag_o) |=> wd_phase_o == `PHASE_FIRST;
	endproperty
	property p_fn_off; forced_normal_flag_o && $past(forced_normal_flag_o) |->
		wd_phase_o == `PHASE_OFF && !sys_reset_o; endproperty
	property p_fn_over; forced_normal_flag_o |-> !sw_dev_flag_o; endproperty
	property p_phase_ok; wd_phase_o != 2'h3; endproperty
	property p_src; sys_reset_o |-> ##[0:1] reset_source_o inside {5'h0e, 5'h0f, 5'h10};
	endproperty
	property p_wake; wd_wake_o |-> s_rxd_low; endproperty
	property p_goto; goto_standby_o |-> $past(wake_event_i) && $past(chip_mode_i) == `CHIP_SLEEP;
	endproperty
	property p_supply; main_supply_on_o && chip_mode_i != `CHIP_SLEEP |=> !main_supply_on_o;
	endproperty
	property p_uv; nv_valid_i |=> uv_threshold_sel_o == uv_hold; endproperty
	property p_nv; s_cfg_wr |=> nv_write_o && nv_wdata_o == (wd_hold & 8'h3d); endproperty
	a_bad_code: assert property (p_bad_code) else $error("bad code not flagged");
	a_fail_cause: assert property (p_fail_cause) else $error("stray spi failure");
	a_trig_phase: assert property (p_trig_phase) else $error("no restart");
	a_fn_off: assert property (p_fn_off) else $error("watchdog on in forced normal");
	a_fn_over: assert property (p_fn_over) else $error("sw dev over forced normal");
	a_phase_ok: assert property (p_phase_ok) else $error("reserved phase");
	a_src: assert property (p_src) else $error("bad reset source");
	a_wake: assert property (p_wake) else $error("wake without rxd low");
	a_goto: assert property (p_goto) else $error("stray standby request");
	a_supply: assert property (p_supply) else $error("supply held");
	a_uv: assert property (p_uv) else $error("threshold not loaded");
	a_nv: assert property (p_nv) else $error("store write wrong");
endmodule
bind sbc_watchdog_config_unit sbc_wd_monitor #(.MS_TICK_CYCLES(MS_TICK_CYCLES),
	.TICK_W(TICK_W)) sbc_wd_monitor_i (.*);

/* sbc_host_model.sv */
// host microcontroller: byte accesses on the decoded register port
// assumes the bench calls one access at a time, after reset
`timescale 1ns/10ps
module sbc_host_model (
	input  wire       clk_i,
	output reg        wr_o,
	output reg        rd_o,
	output reg  [6:0] addr_o,
	output reg  [7:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 7'h00;
		wdata_o = 8'h00;
	end
	// ====
	// one access; mode toggling only in standby is up to the caller
	task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
		int gap;
		gap = $urandom_range(2, 0);
		repeat (gap + 1) @(posedge clk_i);
		#1;
		wr_o = w;
		rd_o = !w;
		addr_o = a;
		wdata_o = d;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		rd_o = 1'b0;
		// released data inverted so no stale value looks valid
		wdata_o = ~d;
	endtask
endmodule

/* tb_top.sv */
// self-checking bench of the watchdog and configuration unit
// assumes the host model and the bound checker
`timescale 1ns/10ps
`include "sbc_wd_regs.vh"
module tb_top;
	localparam int TK = 10;
	logic core_clk_i = 1'b0, arst_n_i = 1'b0, spi_fail_en_i = 1'b1, rxd_low_i = 1'b0;
	logic wake_event_i = 1'b0, sys_reset_i = 1'b0, wd_fail_clear_i = 1'b0;
	logic nv_valid_i = 1'b0, sleep_cmd_i = 1'b0;
	logic [2:0] chip_mode_i = `CHIP_STANDBY;
	logic [7:0] nv_data_i = 8'h00;
	wire reg_wr_i, reg_rd_i, spi_fail_o, nv_write_o, sleep_cmd_ok_o, sys_reset_o;
	wire wd_fail_event_o, wd_wake_o, rxd_force_low_o, main_supply_on_o, goto_standby_o;
	wire forced_normal_flag_o, sw_dev_flag_o;
	wire [6:0] reg_addr_i;
	wire [7:0] reg_wdata_i, reg_rdata_o, nv_wdata_o;
	wire [4:0] reset_source_o;
	wire [1:0] uv_threshold_sel_o, startup_uv_threshold_sel_o, wd_phase_o;
	int failures = 0, cmp_count = 0;
	logic [7:0] expq[$];
	always #2.5 core_clk_i = ~core_clk_i;
	sbc_watchdog_config_unit #(.MS_TICK_CYCLES(TK)) sbc_watchdog_config_unit_i (.*);
	sbc_host_model sbc_host_model_i (.clk_i(core_clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
		.addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
	// ====
	// tasks
	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		cmp_count++;
		if (a !== e) begin
			failures++;
			$display("MISMATCH t=%0t got %h want %h", $time, a, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		sbc_host_model_i.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		expq.push_back(e);
		sbc_host_model_i.access(1'b0, a, 8'h00);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return wd_fail_event_o;
			1: return sys_reset_o;
			2: return wd_wake_o;
			default: return goto_standby_o;
		endcase
	endfunction
	// bounded wait; a run-out ends the run
	task automatic wait_hi(input int s, input int lim, output int n);
		n = 0;
		while (pick(s) !== 1'b1) begin
			cyc(1);
			n++;
			if (n > lim) begin
				failures++;
				$display("MISMATCH t=%0t no event %0d", $time, s);
				give_verdict();
			end
		end
	endtask
	task automatic pulse_clr();
		wd_fail_clear_i = 1'b1;
		cyc(1);
		wd_fail_clear_i = 1'b0;
	endtask
	function automatic logic code_ok(input logic [7:0] b);
		return (b[7:5] inside {3'h1, 3'h2, 3'h4}) &&
			(b[3:0] inside {4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7});
	endfunction
	// ====
	// read watcher: oldest note against the returned byte
	always @(posedge core_clk_i) begin
		if (reg_rd_i === 1'b1) begin
			#1;
			if (expq.size() == 0) chk(8'hxx, 8'h00);
			else chk(reg_rdata_o, expq.pop_front());
		end
	end
	// ====
	// main sequence
	initial begin
		int n;
		logic [7:0] b, cur;
		void'($urandom(32'hf693));
		repeat (4) @(posedge core_clk_i);
		#1;
		arst_n_i = 1'b1;
		cyc(3);
		rd(`ADDR_WD_CONTROL, 8'h44);
		rd(`ADDR_WD_STATUS, 8'h08);
		rd(`ADDR_NV_CONFIG, 8'h08);
		rd(7'h10, 8'h00);
		nv_data_i = 8'h31;
		nv_valid_i = 1'b1;
		sleep_cmd_i = 1'b1;
		cyc(1);
		nv_valid_i = 1'b0;
		cyc(1);
		chk(8'({uv_threshold_sel_o, startup_uv_threshold_sel_o}), 8'h0f);
		chk(8'(sleep_cmd_ok_o), 8'h00);
		wr(`ADDR_NV_CONFIG, 8'hff);
		chk(8'({nv_write_o, forced_normal_flag_o, sw_dev_flag_o}), 8'h06);
		chk(nv_wdata_o, 8'h3d);
		rd(`ADDR_NV_CONFIG, 8'h3d);
		wr(`ADDR_NV_CONFIG, 8'h00);
		chk(8'(sleep_cmd_ok_o), 8'h01);
		sleep_cmd_i = 1'b0;
		// every mode and period code, then random bytes
		cur = 8'h44;
		for (int i = 0; i < 32; i++) begin
			b = 8'($urandom);
			if (i < 8) b = {i[2:0], 5'h04};
			else if (i < 24) b = {3'h2, 1'b0, i[3:0]};
			wr(`ADDR_WD_CONTROL, b);
			chk(8'(spi_fail_o), 8'(!code_ok(b)));
			if (code_ok(b)) cur = b & 8'hef;
			rd(`ADDR_WD_CONTROL, cur);
		end
		spi_fail_en_i = 1'b0;
		wr(`ADDR_WD_CONTROL, 8'h69);
		chk(8'(spi_fail_o), 8'h00);
		pulse_clr();
		// timeout: restart, failure flag, then reset
		wr(`ADDR_WD_CONTROL, 8'h48);
		rd(`ADDR_WD_STATUS, 8'h01);
		cyc(45);
		rd(`ADDR_WD_STATUS, 8'h02);
		wr(`ADDR_WD_CONTROL, 8'h48);
		wait_hi(0, 100, n);
		chk(8'(n >= 70 && n <= 90), 8'h01);
		wait_hi(1, 100, n);
		chk(8'(n >= 70 && n <= 90), 8'h01);
		chk(8'(reset_source_o), 8'h0f);
		rd(`ADDR_WD_CONTROL, 8'h44);
		pulse_clr();
		// window: early trigger, illegal change, good trigger then overflow
		wr(`ADDR_WD_CONTROL, 8'h88);
		chip_mode_i = `CHIP_NORMAL;
		cyc(5);
		wr(`ADDR_WD_CONTROL, 8'h88);
		wait_hi(1, 3, n);
		chk(8'(reset_source_o), 8'h0e);
		cyc(2);
		wr(`ADDR_WD_CONTROL, 8'h28);
		wait_hi(1, 3, n);
		chk(8'(reset_source_o), 8'h10);
		rd(`ADDR_WD_CONTROL, 8'h44);
		chip_mode_i = `CHIP_STANDBY;
		wr(`ADDR_WD_CONTROL, 8'h88);
		chip_mode_i = `CHIP_NORMAL;
		cyc(50);
		wr(`ADDR_WD_CONTROL, 8'h88);
		wait_hi(1, 100, n);
		chk(8'(n >= 70 && n <= 90), 8'h01);
		chk(8'(reset_source_o), 8'h0f);
		// sleep with timeout wakes the host
		chip_mode_i = `CHIP_STANDBY;
		wr(`ADDR_WD_CONTROL, 8'h48);
		chip_mode_i = `CHIP_SLEEP;
		wait_hi(2, 100, n);
		cyc(1);
		chk(8'({wd_fail_event_o, rxd_force_low_o, main_supply_on_o}), 8'h07);
		chip_mode_i = `CHIP_STANDBY;
		pulse_clr();
		// autonomous: off, wake in sleep, restart
		wr(`ADDR_WD_CONTROL, 8'h28);
		rd(`ADDR_WD_STATUS, 8'h00);
		rxd_low_i = 1'b1;
		cyc(2);
		rd(`ADDR_WD_STATUS, 8'h01);
		rxd_low_i = 1'b0;
		cyc(2);
		rd(`ADDR_WD_STATUS, 8'h00);
		chip_mode_i = `CHIP_SLEEP;
		wake_event_i = 1'b1;
		cyc(1);
		wake_event_i = 1'b0;
		wait_hi(3, 3, n);
		cyc(1);
		chk(8'(rxd_force_low_o), 8'h01);
		chip_mode_i = `CHIP_STANDBY;
		cyc(3);
		rd(`ADDR_WD_STATUS, 8'h01);
		// software development mode
		wr(`ADDR_NV_CONFIG, 8'h04);
		sys_reset_i = 1'b1;
		cyc(1);
		sys_reset_i = 1'b0;
		cyc(2);
		rd(`ADDR_WD_CONTROL, 8'h24);
		chip_mode_i = `CHIP_NORMAL;
		cyc(2);
		rd(`ADDR_WD_STATUS, 8'h04);
		chip_mode_i = `CHIP_STANDBY;
		wr(`ADDR_WD_CONTROL, 8'h48);
		rd(`ADDR_WD_STATUS, 8'h05);
		chip_mode_i = 3'h0;
		cyc(2);
		rd(`ADDR_WD_STATUS, 8'h04);
		chip_mode_i = `CHIP_STANDBY;
		wr(`ADDR_NV_CONFIG, 8'h08);
		cyc(2);
		rd(`ADDR_WD_STATUS, 8'h08);
		cyc(2);
		give_verdict();
	end
endmodule
